/* design/temp_period_pkg.sv */
// Constants and state encoding for the sensor period counter.
// Assumes a single 1.2288 MHz reference clock for all logic.
package temp_period_pkg;

    localparam int unsigned COUNT_WIDTH   = 11;
    localparam int unsigned SYNC_STAGES   = 2;
    localparam logic [10:0] COUNT_RESET   = 11'h000;
    localparam logic [10:0] COUNT_ONE     = 11'h001;
    localparam logic [10:0] COUNT_MAX     = 11'h7FF;
    // Expected span of results in 4X mode
    localparam logic [10:0] COUNT_MIN_EXP = 11'h2FE;
    localparam logic [10:0] COUNT_MAX_EXP = 11'h523;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_WAIT_LOW  = 3'b001,
        ST_WAIT_FALL = 3'b010,
        ST_COUNT     = 3'b011,
        ST_DONE      = 3'b100
    } meas_state_type;

endpackage : temp_period_pkg

/* design/temp_period_counter.sv */
// Period counter for a frequency-output temperature sensor.
// Assumes sys_clk_i is the 1.2288 MHz reference; sensor input is asynchronous.
// Assumes the sequencer pulses meas_req_i and waits for meas_done_o before asking again.
//
// Flow of one measurement:
//   idle or done -> wait for a low synchronised input
//   -> wait for a falling edge -> count reference cycles
//   -> closing falling edge -> done, result held on the output
//
// Limitation: a request made while a measurement runs is dropped silently.
// Limitation: a stalled sensor leaves the count saturated at all ones.
//
// Contract
// RULE_01 - After request, search for sensor falling edge; no counting before it.
// RULE_02 - From first falling edge, count each reference cycle until the next.
// RULE_03 - Period counter is eleven bits wide.
// RULE_04 - Count spans exactly one period, about 766 to 1315 in 4X mode.
// RULE_05 - Sensor is strapped for its quadrupled output frequency mode.
// RULE_06 - Edge search waits for low input, then for a valid falling edge.
// RULE_07 - After closing edge, done state asserts completion with stable count.
// RULE_08 - Sequencer pulses request once, waits completion, stores count, repeats.
// RULE_09 - Sensor input synchronised by two flops; counter cleared on accepted request.
`timescale 1ns/1ns

module temp_period_counter
    import temp_period_pkg::*;
(
    input  wire logic                   sys_clk_i,
    input  wire logic                   srst_i,
    input  wire logic                   clk_en_i,
    input  wire logic                   meas_req_i,
    input  wire logic                   sensor_pulse_i,
    output logic                        meas_done_o,
    output logic [COUNT_WIDTH-1:0]      period_count_o
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [SYNC_STAGES-1:0] sync;
        logic                   pulse_prev;
        meas_state_type         state;
        logic [COUNT_WIDTH-1:0] count;
        logic                   done;
        logic [COUNT_WIDTH-1:0] result;
    } regs_type;

    regs_type r_q;
    regs_type r_d;

    // Values taken on reset; the edge history starts low so no false fall follows
    localparam regs_type REGS_RESET = '{
        sync:       '0,
        pulse_prev: 1'b0,
        state:      ST_IDLE,
        count:      COUNT_RESET,
        done:       1'b0,
        result:     COUNT_RESET
    };

    logic pulse_s;
    logic fall_s;
    logic count_full_s;
    logic req_seen_s;

    ////////////////////////////////////////////////////////////////////////
    // Only the second sync stage feeds the edge logic
    assign pulse_s      = r_q.sync[SYNC_STAGES-1];
    assign fall_s       = r_q.pulse_prev & ~pulse_s;
    // Saturation guard for a sensor that never closes its period
    assign count_full_s = (r_q.count == COUNT_MAX);
    // Request level as presented this cycle; acted on only in idle or done
    assign req_seen_s   = meas_req_i;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        r_d            = r_q;
        r_d.sync       = {r_q.sync[SYNC_STAGES-2:0], sensor_pulse_i}; // RULE_09
        r_d.pulse_prev = pulse_s;
        case (r_q.state)
            ST_IDLE: begin
                if (req_seen_s) begin
                    r_d.count = COUNT_RESET; // RULE_09
                    r_d.done  = 1'b0;
                    r_d.state = ST_WAIT_LOW; // RULE_01
                end
            end
            ST_WAIT_LOW: begin
                // A high-to-low already in progress is not trusted as the start
                if (!pulse_s) begin
                    r_d.state = ST_WAIT_FALL; // RULE_06
                end
            end
            ST_WAIT_FALL: begin
                if (fall_s) begin
                    r_d.count = COUNT_ONE; // RULE_02
                    r_d.state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (fall_s) begin
                    r_d.result = r_q.count; // RULE_04
                    r_d.done   = 1'b1; // RULE_07
                    r_d.state  = ST_DONE;
                end else if (!count_full_s) begin
                    // Saturate rather than wrap if the sensor stalls
                    r_d.count = r_q.count + COUNT_ONE; // RULE_03
                end
            end
            ST_DONE: begin
                // Completion held until the next request
                if (req_seen_s) begin
                    r_d.count = COUNT_RESET; // RULE_09
                    r_d.done  = 1'b0;
                    r_d.state = ST_WAIT_LOW; // RULE_08
                end
            end
            default: begin
                r_d.state = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            r_q <= REGS_RESET; // RULE_09
        end else if (clk_en_i) begin
            r_q <= r_d;
        end
    end

    assign meas_done_o    = r_q.done;
    assign period_count_o = r_q.result;

endmodule : temp_period_counter

/* verif/sensor_model.sv */
// Sensor stand-in in 4X mode; each period is latched whole at its falling edge.
`timescale 1ns/1ns
module sensor_model (input wire logic [12:0] period_i, output logic pulse_o);
    int p;
    initial begin
        pulse_o = 1;
        #13;
        forever begin
            pulse_o = 0;
            p = period_i;
            #(p / 2 * 40) pulse_o = 1;
            #((p - p / 2) * 40);
        end
    end
endmodule : sensor_model

/* verif/temp_period_counter_asserts.sv */
// Port checker for the period counter; one clock domain.
`timescale 1ns/1ns
module temp_period_checker (input wire logic sys_clk_i, srst_i, clk_en_i, meas_req_i, meas_done_o,
    input wire logic [10:0] period_count_o);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    req_clear_a: assert property (meas_done_o && meas_req_i && clk_en_i |=> !meas_done_o [*4])
        else $error("done held");
    reset_clear_a: assert property (disable iff (1'b0) srst_i |=> !meas_done_o && period_count_o == 11'h000)
        else $error("reset not clean");
    result_change_a: assert property ($changed(period_count_o) |-> $rose(meas_done_o))
        else $error("result moved without done");
    done_fall_a: assert property ($fell(meas_done_o) |-> $past(meas_req_i && clk_en_i))
        else $error("done dropped without request");
    done_hold_a: assert property (meas_done_o && !meas_req_i |=> meas_done_o && $stable(period_count_o))
        else $error("result moved");
    count_set_a: assert property ($rose(meas_done_o) |-> period_count_o != 11'h000)
        else $error("zero result");
    cover property ($rose(meas_done_o));
    cover property (meas_done_o && meas_req_i);
    cover property (period_count_o == 11'h7FF);
endmodule : temp_period_checker
bind temp_period_counter temp_period_checker u_temp_period_checker (.sys_clk_i, .srst_i, .clk_en_i,
    .meas_req_i, .meas_done_o, .period_count_o);

/* verif/tb_temp_period_counter.sv */
// Bench: table of sensor periods beside expected counts.
`timescale 1ns/1ns
module tb_temp_period_counter;
    logic        sys_clk_i = 0, srst_i = 1, meas_req_i = 0, sensor_pulse_i, meas_done_o;
    logic        clk_en_i = 1;
    logic [10:0] period_count_o;
    logic [12:0] period = 13'h3E8;
    int          err_count = 0, checked = 0;
    logic [12:0] rows [4][2] = '{'{13'h2FE, 13'h2FE}, '{13'h523, 13'h523}, '{13'h3E8, 13'h3E8}, '{13'h1388, 13'h7FF}};
    always #20 sys_clk_i = ~sys_clk_i;
    sensor_model u_sensor_model (.period_i(period), .pulse_o(sensor_pulse_i));
    temp_period_counter u_temp_period_counter (.sys_clk_i, .srst_i, .clk_en_i, .meas_req_i,
        .sensor_pulse_i, .meas_done_o, .period_count_o);
    task automatic chk(string n, logic [10:0] s, e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (12) @(posedge sys_clk_i);
        #2 srst_i = 0;
        chk("rst", period_count_o, 11'h000);
        chk("rst_done", 11'(meas_done_o), 11'h000);
        foreach (rows[r]) begin
            period = rows[r][0];
            @(posedge sys_clk_i) #2 meas_req_i = 1;
            @(posedge sys_clk_i) #2 meas_req_i = 0;
            chk("done", 11'(meas_done_o), 11'h000);
            repeat (20) @(posedge sys_clk_i);
            #2 meas_req_i = 1; // Ignored while waiting for the falling edge
            @(posedge sys_clk_i) #2 meas_req_i = 0;
            for (int i = 0; i < 16000 && !meas_done_o; i++) @(posedge sys_clk_i) #2;
            chk("count", period_count_o, rows[r][1][10:0]);
        end
        // Frozen block keeps result and ignores a request
        @(posedge sys_clk_i) #2 clk_en_i = 0;
        meas_req_i = 1;
        @(posedge sys_clk_i) #2 meas_req_i = 0;
        repeat (4) @(posedge sys_clk_i);
        #2 chk("frz_done", 11'(meas_done_o), 11'h001);
        chk("frz_cnt", period_count_o, 11'h7FF);
        clk_en_i = 1;
        // Reset in mid-measurement
        @(posedge sys_clk_i) #2 meas_req_i = 1;
        @(posedge sys_clk_i) #2 meas_req_i = 0;
        repeat (50) @(posedge sys_clk_i);
        #2 srst_i = 1;
        repeat (2) @(posedge sys_clk_i);
        #2 srst_i = 0;
        chk("mid_done", 11'(meas_done_o), 11'h000);
        chk("mid_cnt", period_count_o, 11'h000);
        period = 13'h3E8;
        repeat (3) @(posedge sys_clk_i);
        #2 meas_req_i = 1;
        @(posedge sys_clk_i) #2 meas_req_i = 0;
        for (int i = 0; i < 16000 && !meas_done_o; i++) @(posedge sys_clk_i) #2;
        chk("post_rst", period_count_o, 11'h3E8);
        wrap_up();
    end
    initial begin
        #2400000 err_count++;
        wrap_up();
    end
endmodule : tb_temp_period_counter
